// ===== design/xcs_base_decode.v
// Base address registers for expansion-bus chip selects two and three, decode for select two only
`timescale 1ns/1ps
`include "xcs_consts.vh"

module xcs_base_decode #(
   parameter ADDR_W = 16
) (
   input  wire              core_clk,
   input  wire              reset,
   input  wire              soft_reset,
   input  wire [7:0]        reg_addr,
   input  wire [7:0]        reg_wdata,
   input  wire              reg_wr,
   input  wire              reg_rd,
   output reg  [7:0]        reg_rdata,
   input  wire              xbus_mode,
   input  wire              cs3_lock,
   input  wire [ADDR_W-1:0] io_addr,
   input  wire              io_valid,
   output reg               expansion_select_two_n,
   output reg  [7:0]        cs3_base_high_q
);

   // Three configuration bytes hold the bases of selects two and three. The
   // select two bank carries its own lock and disable bits in its low byte;
   // the select three lock lives in a register outside this block and comes
   // in as a level. The hard reset stands for every power-on and bus reset,
   // the soft reset clears addresses and disable but never the lock.
   // Decode is registered, so the select pin lags the host address by one
   // clock; the host address is only looked at on the clock edge.
   // Nothing here raises an interrupt or reports a refused write.

   // Stored register state
   reg [7:0] cs2_base_high;
   reg [5:0] cs2_low_addr;
   reg       cs2_lock;
   reg       cs2_disable;

   // Compare a host address with a programmed base; the mode picks the width
   function match_base;
      input [15:0] addr;
      input [15:0] base;
      input        mode2;
      begin
         if (mode2) begin
            match_base = (addr[15:4] == base[15:4]);
         end else begin
            match_base = (addr[15:2] == base[15:2]);
         end
      end
   endfunction

   // Offset decode, shared by the three write strobes
   function is_offset;
      input [7:0] addr;
      input [7:0] offset;
      begin
         is_offset = (addr == offset);
      end
   endfunction

   // Read view of the select two low byte. In mode 2 bits 3:2 are reserved:
   // they stay stored, so a later switch back to mode 1 finds them intact,
   // but they read zero and take no part in the compare
   function [7:0] low_view;
      input [5:0] low_addr;
      input       lock;
      input       disable_bit;
      input       mode2;
      reg   [7:0] view;
      begin
         view = {low_addr, lock, disable_bit};
         if (mode2) begin
            view[`XCS_LOW_RSVD_MSB:`XCS_LOW_RSVD_LSB] = 2'b00;
         end
         low_view = view;
      end
   endfunction

   // Register decode strobes
   // Unmapped offsets hit none of them, so writes there are dropped
   wire wr_cs2_high = reg_wr && is_offset(reg_addr, `XCS_OFF_CS2_BASE_HIGH);
   wire wr_cs2_low  = reg_wr && is_offset(reg_addr, `XCS_OFF_CS2_BASE_LOW_CTRL);
   wire wr_cs3_high = reg_wr && is_offset(reg_addr, `XCS_OFF_CS3_BASE_HIGH);

   // Write permission; a locked register drops writes without any error
   // indication, software has to read back to find out
   wire cs2_writable = !cs2_lock;
   wire cs3_writable = !cs3_lock;

   // Next values of every flop
   // Only the combinational processes below write them
   reg [7:0] next_cs2_base_high;
   reg [5:0] next_cs2_low_addr;
   reg       next_cs2_disable;
   reg       next_cs2_lock;
   reg [7:0] next_cs3_base_high;
   reg [7:0] next_reg_rdata;
   reg       next_select_two_n;

   // Full 16-bit base of select two, low two bits are never compared
   wire [15:0] cs2_base = {cs2_base_high, cs2_low_addr, 2'b00};

   // Low register as software reads it
   wire [7:0] cs2_low_view = low_view(cs2_low_addr, cs2_lock, cs2_disable, xbus_mode);

   // Top address bits are qualified as well; a base with 15:12 set never matches
   // anything the host can place below 0x1000, which software must respect
   wire top_ok = (io_addr[15:12] == cs2_base[15:12]);

   // Address fields and disable bit. Soft reset beats a write in the same
   // cycle and ignores the lock, so even a locked bank returns to zero.
   // The lock itself survives, which keeps the zeroed bank read-only.
   always @* begin
      next_cs2_base_high = cs2_base_high;
      next_cs2_low_addr  = cs2_low_addr;
      next_cs2_disable   = cs2_disable;
      if (soft_reset) begin
         next_cs2_base_high = `XCS_RST_BASE_HIGH;
         next_cs2_low_addr  = `XCS_RST_LOW_ADDR;
         next_cs2_disable   = `XCS_RST_BIT;
      end else begin
         // High byte carries address 15:8
         if (wr_cs2_high && cs2_writable) begin
            next_cs2_base_high = reg_wdata;
         end
         // Low byte carries address bits 7:2 and the disable bit
         if (wr_cs2_low && cs2_writable) begin
            next_cs2_low_addr = reg_wdata[`XCS_LOW_ADDR_MSB:`XCS_LOW_ADDR_LSB];
            next_cs2_disable  = reg_wdata[`XCS_LOW_DISABLE_BIT];
         end
      end
   end

   // Select three high byte; the cs3_lock level from outside this block freezes it against writes, not against soft reset
   always @* begin
      next_cs3_base_high = cs3_base_high_q;
      if (soft_reset) begin
         next_cs3_base_high = `XCS_RST_BASE_HIGH;
      end else if (wr_cs3_high && cs3_writable) begin
         next_cs3_base_high = reg_wdata;
      end
   end

   // Lock: set-only from software and blind to soft reset. Writing a zero
   // never clears it, so a stray write cannot reopen the bank.
   always @* begin
      next_cs2_lock = cs2_lock;
      if (wr_cs2_low && reg_wdata[`XCS_LOW_LOCK_BIT]) begin
         next_cs2_lock = 1'b1;
      end
   end

   // Read mux; without a read strobe the data bus idles at zero.
   // Unmapped offsets read zero as well, and no read has a side effect.
   always @* begin
      next_reg_rdata = `XCS_RDATA_NONE;
      if (reg_rd) begin
         case (reg_addr)
            `XCS_OFF_CS2_BASE_HIGH:     next_reg_rdata = cs2_base_high;
            `XCS_OFF_CS2_BASE_LOW_CTRL: next_reg_rdata = cs2_low_view;
            `XCS_OFF_CS3_BASE_HIGH:     next_reg_rdata = cs3_base_high_q;
            default:                    next_reg_rdata = `XCS_RDATA_NONE;
         endcase
      end
   end

   // Select two decode; a hit needs a host cycle, an enabled select and a match
   always @* begin
      next_select_two_n = 1'b1;
      if (io_valid && !cs2_disable && top_ok
          && match_base(io_addr, cs2_base, xbus_mode)) begin
         next_select_two_n = 1'b0;
      end
   end

   // Address and disable flops; the hard reset stands for every power-on
   // and bus reset
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cs2_base_high   <= `XCS_RST_BASE_HIGH;
         cs2_low_addr    <= `XCS_RST_LOW_ADDR;
         cs2_disable     <= `XCS_RST_BIT;
         cs3_base_high_q <= `XCS_RST_BASE_HIGH;
      end else begin
         cs2_base_high   <= next_cs2_base_high;
         cs2_low_addr    <= next_cs2_low_addr;
         cs2_disable     <= next_cs2_disable;
         cs3_base_high_q <= next_cs3_base_high;
      end
   end

   // Lock flop in a process of its own, so soft reset cannot reach it;
   // only the hard reset clears it
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         cs2_lock <= `XCS_RST_BIT;
      end else begin
         cs2_lock <= next_cs2_lock;
      end
   end

   // Read data flop; stands for the one cycle after the strobe only
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         reg_rdata <= `XCS_RDATA_NONE;
      end else begin
         reg_rdata <= next_reg_rdata;
      end
   end

   // Select flop keeps the pin glitch free; costs one cycle of latency.
   // Held high in reset so no device is selected before software runs.
   always @(posedge core_clk or posedge reset) begin
      if (reset) begin
         expansion_select_two_n <= 1'b1;
      end else begin
         expansion_select_two_n <= next_select_two_n;
      end
   end

endmodule // xcs_base_decode

// ===== design/xcs_consts.vh
// Offsets, field positions and reset values of the expansion-bus select base registers
`ifndef XCS_CONSTS_VH
`define XCS_CONSTS_VH

// Register offsets in configuration space
`define XCS_OFF_CS2_BASE_HIGH     8'h64
`define XCS_OFF_CS2_BASE_LOW_CTRL 8'h65
`define XCS_OFF_CS3_BASE_HIGH     8'h66

// Fields of the select two low/control register
`define XCS_LOW_DISABLE_BIT       0
`define XCS_LOW_LOCK_BIT          1
`define XCS_LOW_ADDR_MSB          7
`define XCS_LOW_ADDR_LSB          2
`define XCS_LOW_RSVD_MSB          3
`define XCS_LOW_RSVD_LSB          2

// Reset values
`define XCS_RST_BASE_HIGH         8'h00
`define XCS_RST_LOW_ADDR          6'h00
`define XCS_RST_BIT               1'b0
`define XCS_RDATA_NONE            8'h00

// Upper address bits that must stay zero in any base
`define XCS_ADDR_TOP_ZERO         4'h0

`endif

// ===== tb/xcs_mon_monitor.sv
// Port checker for the select base bank
`timescale 1ns/1ps
module xcs_mon(input wire logic core_clk, reset, soft_reset, reg_wr, reg_rd, xbus_mode,
   cs3_lock, io_valid, expansion_select_two_n,
   input wire logic [7:0] reg_addr, reg_wdata, reg_rdata, cs3_base_high_q,
   input wire logic [15:0] io_addr);
default clocking @(posedge core_clk); endclocking
default disable iff (reset);
property p_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
a_idle: assert property (p_idle) else $error("rdata not idle");
property p_unmap; $past(reg_rd) && $past(reg_addr) > 8'h66 |-> reg_rdata == 8'h00; endproperty
a_unmap: assert property (p_unmap) else $error("unmapped data");
property p_rsv; $past(reg_rd) && $past(reg_addr) == 8'h65 && $past(xbus_mode)
   |-> reg_rdata[3:2] == 2'b00; endproperty
a_rsv: assert property (p_rsv) else $error("reserved bits");
property p_nosel; !io_valid |=> expansion_select_two_n; endproperty
a_nosel: assert property (p_nosel) else $error("select idle");
property p_wr3; reg_wr && reg_addr == 8'h66 && !cs3_lock && !soft_reset
   |=> cs3_base_high_q == $past(reg_wdata); endproperty
a_wr3: assert property (p_wr3) else $error("cs3 write");
property p_lk3; cs3_lock && !soft_reset |=> $stable(cs3_base_high_q); endproperty
a_lk3: assert property (p_lk3) else $error("cs3 lock");
property p_hold3; !reg_wr && !soft_reset |=> $stable(cs3_base_high_q); endproperty
a_hold3: assert property (p_hold3) else $error("cs3 hold");
property p_soft; soft_reset |=> cs3_base_high_q == 8'h00; endproperty
a_soft: assert property (p_soft) else $error("soft clear");
endmodule // xcs_mon
bind xcs_base_decode xcs_mon u_xcs_mon(.core_clk(core_clk), .reset(reset),
   .soft_reset(soft_reset), .reg_wr(reg_wr), .reg_rd(reg_rd), .xbus_mode(xbus_mode),
   .cs3_lock(cs3_lock), .io_valid(io_valid), .expansion_select_two_n(expansion_select_two_n),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
   .cs3_base_high_q(cs3_base_high_q), .io_addr(io_addr));

// ===== tb/xcs_host.sv
// Host model issuing I/O cycles
`timescale 1ns/1ps
module xcs_host(input wire logic core_clk, go, input wire logic [15:0] ha,
   output logic io_valid = 0, output logic [15:0] io_addr = 0);
// Idle address flips so a stale value never decodes
always @(posedge core_clk) begin
   io_valid <= go;
   io_addr <= go ? ha : ~io_addr;
end
endmodule // xcs_host

// ===== tb/tb.sv
// Bench for the select base bank
`timescale 1ns/1ps
module tb;
logic core_clk = 0, reset = 1, soft_reset = 0, reg_wr = 0, reg_rd = 0, xbus_mode = 0;
logic cs3_lock = 0, go = 0, rd_d = 0, v_d = 0, io_valid, expansion_select_two_n;
logic [7:0] reg_addr = 0, reg_wdata = 0, reg_rdata, cs3_base_high_q, hi, lo, q[$], sq[$];
logic [15:0] ha = 0, io_addr;
int err_total = 0, n_checks = 0;
always #4 core_clk = ~core_clk;
xcs_base_decode u_xcs_base_decode(.core_clk(core_clk), .reset(reset), .soft_reset(soft_reset),
   .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
   .reg_rdata(reg_rdata), .xbus_mode(xbus_mode), .cs3_lock(cs3_lock), .io_addr(io_addr),
   .io_valid(io_valid), .expansion_select_two_n(expansion_select_two_n),
   .cs3_base_high_q(cs3_base_high_q));
xcs_host u_xcs_host(.core_clk(core_clk), .go(go), .ha(ha), .io_valid(io_valid),
   .io_addr(io_addr));
// Read data compare
task chk_rd(input logic [7:0] g, e);
   n_checks++;
   if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t %h %h", $time, g, e);
   end
endtask
// Select pin compare, pin in bit 0
task chk_sel(input logic [7:0] g, e);
   n_checks++;
   if (g !== e) begin
      err_total++;
      $display("MISMATCH %0t %h %h", $time, g, e);
   end
endtask
task op(input logic w, r, input logic [7:0] a, d);
   reg_wr <= w; reg_rd <= r; reg_addr <= a; reg_wdata <= d;
   @(posedge core_clk);
endtask
task rd(input logic [7:0] a, e); q.push_back(e); op(0, 1, a, 0); endtask
// Strobes drop while the host cycle runs
task io(input logic [15:0] a, input logic [7:0] e);
   sq.push_back(e); reg_wr <= 0; reg_rd <= 0; go <= 1; ha <= a;
   @(posedge core_clk);
   go <= 0;
   repeat (3) @(posedge core_clk);
endtask
task print_verdict;
   $display("checks %0d errors %0d", n_checks, err_total);
   if (err_total == 0 && n_checks > 0) $display("Regression OK");
   else $display("Regression broken");
   $finish;
endtask
// Scoreboard pops the oldest note per result
always @(posedge core_clk) begin
   rd_d <= reg_rd;
   v_d <= io_valid;
   if (rd_d) chk_rd(reg_rdata, q.pop_front());
   if (v_d) chk_sel({7'h0, expansion_select_two_n}, sq.pop_front());
end
initial begin
   #20000 err_total++;
   print_verdict;
end
initial begin
   void'($urandom(32'h155e));
   hi = {4'h0, 4'($urandom)};
   lo = 8'($urandom) & 8'hfc;
   repeat (8) @(posedge core_clk);
   reset <= 0;
   @(posedge core_clk);
   rd(8'h64, 0); rd(8'h65, 0); rd(8'h70, 0);
   op(1, 0, 8'h64, hi); op(1, 0, 8'h65, lo);
   rd(8'h64, hi); rd(8'h65, lo);
   io({hi, lo}, 0); io({hi, lo} ^ 16'h0004, 1);
   xbus_mode <= 1;
   io({hi, lo} ^ 16'h000c, 0); rd(8'h65, lo & 8'hf0);
   op(1, 0, 8'h65, lo | 8'h01); io({hi, lo}, 1);
   op(1, 0, 8'h65, 8'h02); op(1, 0, 8'h64, ~hi); op(1, 0, 8'h65, 0);
   rd(8'h64, hi); rd(8'h65, 8'h02);
   op(1, 0, 8'h66, hi); cs3_lock <= 1;
   op(1, 0, 8'h66, ~hi); rd(8'h66, hi);
   cs3_lock <= 0; op(0, 0, 0, 0); soft_reset <= 1;
   @(posedge core_clk);
   soft_reset <= 0;
   rd(8'h64, 0); rd(8'h66, 0); rd(8'h65, 8'h02);
   op(0, 0, 0, 0); reset <= 1;
   @(posedge core_clk);
   reset <= 0;
   @(posedge core_clk);
   rd(8'h65, 0); op(0, 0, 0, 0);
   @(posedge core_clk);
   print_verdict;
end
endmodule // tb
